// File: inc/timer2_regs.svh
// Function
// - overflow sets overflow flag unless baud clocking
// - trigger-caused capture or reload sets external event flag
// - receive select routes overflow pulses to receiver
// - transmit select routes overflow pulses to transmitter
// - trigger enable allows trigger edges, else ignored
// - run control starts and stops the timer
// - counter select picks pin events or clock
// - capture select ignored in baud, autoreload forced
// - mode decode: off, baud, capture, autoreload
// - autoreload overflow loads count from reload bytes
// - autoreload trigger edge reloads, sets event flag
// - capture without trigger is plain 16-bit counter
// - capture trigger copies count into capture bytes
// - baud mode never sets overflow flag
// - both flags raise the interrupt request
// - control resets to zero, bit addressable
`ifndef TIMER2_REGS_SVH
`define TIMER2_REGS_SVH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define T2_CTRL_ADDR        8'hC8
`define T2_RELOAD_LOW_ADDR  8'hCA
`define T2_RELOAD_HIGH_ADDR 8'hCB
`define T2_COUNT_LOW_ADDR   8'hCC
`define T2_COUNT_HIGH_ADDR  8'hCD
`define T2_BIT_BASE         5'h19

// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define T2_BIT_OVF          3'h7
`define T2_BIT_EXT          3'h6
`define T2_BIT_RXSEL        3'h5
`define T2_BIT_TXSEL        3'h4
`define T2_BIT_TRIGEN       3'h3
`define T2_BIT_RUN          3'h2
`define T2_BIT_CNTSEL       3'h1
`define T2_BIT_CAPSEL       3'h0

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define T2_CTRL_RESET       8'h00
`define T2_WORD_RESET       16'h0000
`define T2_BYTE_ZERO        8'h00
`define T2_COUNT_MAX        16'hFFFF
`define T2_COUNT_STEP       16'h0001
`define T2_PIN_IDLE         1'b1

`endif

// File: inc/timer2_pkg.sv
package timer2_pkg;

    typedef enum logic [1:0]
    {
        MODE_OFF        = 2'b00,
        MODE_AUTORELOAD = 2'b01,
        MODE_CAPTURE    = 2'b10,
        MODE_BAUD       = 2'b11
    } timer_mode_e;

    typedef struct packed
    {
        logic [15:0] count;
        logic [15:0] reload;
        logic        overflow_flag;
        logic        external_event_flag;
        logic        receive_clock_select;
        logic        transmit_clock_select;
        logic        trigger_enable;
        logic        run_control;
        logic        counter_select;
        logic        capture_select;
        logic        rx_pulse;
        logic        tx_pulse;
        logic        irq;
    } timer_state_s;

    typedef struct packed
    {
        logic sync1;
        logic sync2;
        logic prev;
    } edge_sync_s;

    typedef struct packed
    {
        logic [7:0] rdata;
    } read_port_s;

endpackage : timer2_pkg

// File: rtl/pin_fall_sync.sv
`timescale 1ns/1ns
`include "timer2_regs.svh"

module pin_fall_sync
    import timer2_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic pin,
    output      logic fall
);

    edge_sync_s st;
    edge_sync_s next_st;

    // ----------------------------------------------------------------
    // two-stage synchroniser and falling edge
    // ----------------------------------------------------------------
    // sync1 feeds only sync2; the edge looks at sync2 and prev
    always_comb
    begin
        next_st       = st;
        next_st.sync1 = pin;
        next_st.sync2 = st.sync1;
        next_st.prev  = st.sync2;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            // idle high so release from reset makes no false edge
            st <= '{sync1: `T2_PIN_IDLE, sync2: `T2_PIN_IDLE, prev: `T2_PIN_IDLE};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign fall = st.prev & ~st.sync2;

endmodule : pin_fall_sync

// File: rtl/sfr_read_port.sv
`timescale 1ns/1ns
`include "timer2_regs.svh"

module sfr_read_port
    import timer2_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  sfr_addr,
    input  wire logic        sfr_rd,
    input  wire logic [7:0]  ctrl_byte,
    input  wire logic [15:0] reload,
    input  wire logic [15:0] count,
    output      logic [7:0]  sfr_rdata
);

    read_port_s st;
    read_port_s next_st;

    // ----------------------------------------------------------------
    // registered read decode
    // ----------------------------------------------------------------
    // data holds between reads; unmapped addresses read zero
    always_comb
    begin
        next_st = st;
        if (sfr_rd)
        begin
            if (sfr_addr == `T2_CTRL_ADDR)
                next_st.rdata = ctrl_byte;
            else if (sfr_addr == `T2_RELOAD_LOW_ADDR)
                next_st.rdata = reload[7:0];
            else if (sfr_addr == `T2_RELOAD_HIGH_ADDR)
                next_st.rdata = reload[15:8];
            else if (sfr_addr == `T2_COUNT_LOW_ADDR)
                next_st.rdata = count[7:0];
            else if (sfr_addr == `T2_COUNT_HIGH_ADDR)
                next_st.rdata = count[15:8];
            else
                next_st.rdata = `T2_BYTE_ZERO;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '{rdata: `T2_BYTE_ZERO};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign sfr_rdata = st.rdata;

endmodule : sfr_read_port

// File: rtl/timer2_capture_reload.sv
`timescale 1ns/1ns
`include "timer2_regs.svh"

module timer2_capture_reload
    import timer2_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       rst_n,
    input  wire logic [7:0] sfr_addr,
    input  wire logic       sfr_wr,
    input  wire logic [7:0] sfr_wdata,
    input  wire logic       sfr_rd,
    output      logic [7:0] sfr_rdata,
    input  wire logic [7:0] bit_addr,
    input  wire logic       bit_wr,
    input  wire logic       bit_wdata,
    input  wire logic       count_input_pin,
    input  wire logic       trigger_pin,
    output      logic       rx_baud_pulse,
    output      logic       tx_baud_pulse,
    output      logic       rx_clock_from_timer,
    output      logic       tx_clock_from_timer,
    output      logic       irq
);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic byte_hit(input logic [7:0] addr, input logic [7:0] target);
        byte_hit = (addr == target);
    endfunction : byte_hit

    function automatic logic [7:0] pack_ctrl(input timer_state_s s);
        logic [7:0] c;
        c                 = `T2_CTRL_RESET;
        c[`T2_BIT_OVF]    = s.overflow_flag;
        c[`T2_BIT_EXT]    = s.external_event_flag;
        c[`T2_BIT_RXSEL]  = s.receive_clock_select;
        c[`T2_BIT_TXSEL]  = s.transmit_clock_select;
        c[`T2_BIT_TRIGEN] = s.trigger_enable;
        c[`T2_BIT_RUN]    = s.run_control;
        c[`T2_BIT_CNTSEL] = s.counter_select;
        c[`T2_BIT_CAPSEL] = s.capture_select;
        pack_ctrl         = c;
    endfunction : pack_ctrl

    timer_state_s st;
    timer_state_s next_st;
    timer_mode_e  mode;
    logic         count_fall;
    logic         trigger_fall;
    logic         tick;
    logic         overflow;
    logic         trig;
    logic         ctrl_wr;
    logic         ctrl_bit_wr;
    logic         count_wr;
    logic         reload_wr;
    logic [7:0]   ctrl_byte;
    logic [7:0]   ctrl_new;
    logic [15:0]  count_inc;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    pin_fall_sync u_count_sync
    (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (count_input_pin),
        .fall  (count_fall)
    );

    pin_fall_sync u_trigger_sync
    (
        .clk   (clk),
        .rst_n (rst_n),
        .pin   (trigger_pin),
        .fall  (trigger_fall)
    );

    // ----------------------------------------------------------------
    // mode decode and count events
    // ----------------------------------------------------------------
    always_comb
    begin
        if (!st.run_control)
            mode = MODE_OFF;
        else if (st.receive_clock_select || st.transmit_clock_select)
            mode = MODE_BAUD;
        else if (st.capture_select)
            mode = MODE_CAPTURE;
        else
            mode = MODE_AUTORELOAD;
    end

    assign ctrl_byte   = pack_ctrl(st);
    assign tick        = st.run_control && (st.counter_select ? count_fall : 1'b1);
    assign overflow    = tick && (st.count == `T2_COUNT_MAX);
    // trigger edges only act while running and enabled
    assign trig        = trigger_fall && st.trigger_enable && st.run_control;
    assign count_inc   = 16'(st.count + `T2_COUNT_STEP);
    assign ctrl_wr     = sfr_wr && byte_hit(sfr_addr, `T2_CTRL_ADDR);
    assign ctrl_bit_wr = bit_wr && (bit_addr[7:3] == `T2_BIT_BASE);
    assign count_wr    = sfr_wr && (byte_hit(sfr_addr, `T2_COUNT_LOW_ADDR) ||
                                    byte_hit(sfr_addr, `T2_COUNT_HIGH_ADDR));
    assign reload_wr   = sfr_wr && (byte_hit(sfr_addr, `T2_RELOAD_LOW_ADDR) ||
                                    byte_hit(sfr_addr, `T2_RELOAD_HIGH_ADDR));

    // ----------------------------------------------------------------
    // control byte after software writes
    // ----------------------------------------------------------------
    always_comb
    begin
        ctrl_new = ctrl_byte;
        if (ctrl_wr)
            ctrl_new = sfr_wdata;
        else if (ctrl_bit_wr)
            ctrl_new[bit_addr[2:0]] = bit_wdata;
    end

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_st = st;

        next_st.receive_clock_select  = ctrl_new[`T2_BIT_RXSEL];
        next_st.transmit_clock_select = ctrl_new[`T2_BIT_TXSEL];
        next_st.trigger_enable        = ctrl_new[`T2_BIT_TRIGEN];
        next_st.run_control           = ctrl_new[`T2_BIT_RUN];
        next_st.counter_select        = ctrl_new[`T2_BIT_CNTSEL];
        next_st.capture_select        = ctrl_new[`T2_BIT_CAPSEL];

        // hardware set wins over a software clear in the same cycle
        next_st.overflow_flag       = ctrl_new[`T2_BIT_OVF] ||
                                      (overflow && (mode != MODE_BAUD));
        next_st.external_event_flag = ctrl_new[`T2_BIT_EXT] || trig;

        case (mode)
            MODE_AUTORELOAD:
            begin
                if (overflow || trig)
                    next_st.count = st.reload;
                else if (tick)
                    next_st.count = count_inc;
            end
            MODE_CAPTURE:
            begin
                if (tick)
                    next_st.count = count_inc;
            end
            MODE_BAUD:
            begin
                // trigger edges only flag here; no reload from the pin
                if (overflow)
                    next_st.count = st.reload;
                else if (tick)
                    next_st.count = count_inc;
            end
            default:
            begin
                next_st.count = st.count;
            end
        endcase

        if (sfr_wr && byte_hit(sfr_addr, `T2_COUNT_LOW_ADDR))
            next_st.count[7:0] = sfr_wdata;
        if (sfr_wr && byte_hit(sfr_addr, `T2_COUNT_HIGH_ADDR))
            next_st.count[15:8] = sfr_wdata;

        if (reload_wr && byte_hit(sfr_addr, `T2_RELOAD_LOW_ADDR))
            next_st.reload[7:0] = sfr_wdata;
        if (reload_wr && byte_hit(sfr_addr, `T2_RELOAD_HIGH_ADDR))
            next_st.reload[15:8] = sfr_wdata;
        // a capture edge beats a same-cycle software write to the capture bytes
        if ((mode == MODE_CAPTURE) && trig)
            next_st.reload = st.count;

        next_st.rx_pulse = overflow && (mode == MODE_BAUD) && st.receive_clock_select;
        next_st.tx_pulse = overflow && (mode == MODE_BAUD) && st.transmit_clock_select;
        next_st.irq      = next_st.overflow_flag || next_st.external_event_flag;
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            st <= '{count: `T2_WORD_RESET, reload: `T2_WORD_RESET, default: 1'b0};
        end
        else
        begin
            st <= next_st;
        end
    end

    // ----------------------------------------------------------------
    // read port and outputs
    // ----------------------------------------------------------------
    sfr_read_port u_read_port
    (
        .clk       (clk),
        .rst_n     (rst_n),
        .sfr_addr  (sfr_addr),
        .sfr_rd    (sfr_rd),
        .ctrl_byte (ctrl_byte),
        .reload    (st.reload),
        .count     (st.count),
        .sfr_rdata (sfr_rdata)
    );

    assign rx_baud_pulse       = st.rx_pulse;
    assign tx_baud_pulse       = st.tx_pulse;
    assign rx_clock_from_timer = st.receive_clock_select;
    assign tx_clock_from_timer = st.transmit_clock_select;
    assign irq                 = st.irq;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    AST_OVF_SETS_FLAG: assert property (
        (overflow && (mode != MODE_BAUD)) |=> st.overflow_flag)
        else $error("overflow did not set overflow flag");

    AST_EXT_SETS_FLAG: assert property (
        trig |=> (st.external_event_flag && irq))
        else $error("trigger edge did not set event flag and irq");

    AST_RX_PULSE: assert property (
        (overflow && (mode == MODE_BAUD) && st.receive_clock_select) |=> rx_baud_pulse ##1 (!rx_baud_pulse || $past(overflow)))
        else $error("receive baud pulse missing or too long");

    AST_TX_PULSE: assert property (
        tx_baud_pulse |-> $past(overflow) && $past(st.transmit_clock_select))
        else $error("transmit baud pulse without cause");

    AST_TRIG_IGNORED: assert property (
        (trigger_fall && !st.trigger_enable && !st.external_event_flag && !ctrl_wr && !ctrl_bit_wr)
        |=> !st.external_event_flag)
        else $error("trigger edge not ignored while disabled");

    AST_OFF_HOLDS: assert property (
        ((mode == MODE_OFF) && !count_wr) |=> (st.count == $past(st.count)))
        else $error("count moved while timer off");

    AST_TIMER_INC: assert property (
        ((mode == MODE_CAPTURE) && !st.counter_select && !overflow && !count_wr)
        |=> (st.count == 16'($past(st.count) + `T2_COUNT_STEP)))
        else $error("timer did not count the core clock");

    AST_RELOAD_ON_OVF: assert property (
        ((mode == MODE_AUTORELOAD) && overflow && !count_wr) |=> (st.count == $past(st.reload)))
        else $error("autoreload did not load count");

    AST_CAPTURE_COPY: assert property (
        ((mode == MODE_CAPTURE) && trig) |=> (st.reload == $past(st.count)))
        else $error("capture did not copy count");

    AST_BAUD_NO_OVF: assert property (
        ((mode == MODE_BAUD) && !st.overflow_flag && !ctrl_wr && !ctrl_bit_wr) |=> !st.overflow_flag)
        else $error("overflow flag set in baud mode");

    AST_BIT_WRITE_RUN: assert property (
        (bit_wr && (bit_addr == 8'(`T2_CTRL_ADDR + `T2_BIT_RUN)) && !ctrl_wr)
        |=> (st.run_control == $past(bit_wdata)))
        else $error("bit write did not reach run control");

    COV_CAPTURE: cover property ((mode == MODE_CAPTURE) && trig);
    COV_AUTORELOAD_OVF: cover property ((mode == MODE_AUTORELOAD) && overflow);
    COV_BAUD_PULSE: cover property (rx_baud_pulse && tx_baud_pulse);
    COV_BAUD_EVENT: cover property ((mode == MODE_BAUD) && trig);

endmodule : timer2_capture_reload

// File: bench/pin_driver.sv
`timescale 1ns/1ns

// ----------------------------------------------------------------
// far side: external count and trigger pins
// ----------------------------------------------------------------
module pin_driver
(
    input  wire logic clk,
    output      logic count_input_pin,
    output      logic trigger_pin
);
    // both pins idle high, so a falling edge is the event
    initial
    begin
        count_input_pin = 1'b1;
        trigger_pin     = 1'b1;
    end

    // four cycles per level, well over the one-cycle minimum of the synchroniser
    task automatic pulse_pin(input bit trig);
        @(negedge clk);
        if (trig)
            trigger_pin = 1'b0;
        else
            count_input_pin = 1'b0;
        repeat (4) @(negedge clk);
        if (trig)
            trigger_pin = 1'b1;
        else
            count_input_pin = 1'b1;
        repeat (4) @(negedge clk);
    endtask : pulse_pin
endmodule : pin_driver

// File: bench/tb_top.sv
`timescale 1ns/1ns
`include "timer2_regs.svh"

`define CHK(nm, exp, got) \
    begin cmp_count++; if ((got) !== (exp)) begin fails++; \
    $display("[FAIL] %s expected %0h seen %0h", nm, exp, got); end end

module tb_top;
    // ----------------------------------------------------------------
    // signals
    // ----------------------------------------------------------------
    logic       clk;
    logic       rst_n;
    logic [7:0] sfr_addr;
    logic       sfr_wr;
    logic [7:0] sfr_wdata;
    logic       sfr_rd;
    logic [7:0] sfr_rdata;
    logic [7:0] bit_addr;
    logic       bit_wr;
    logic       bit_wdata;
    logic       count_input_pin;
    logic       trigger_pin;
    logic       rx_baud_pulse;
    logic       tx_baud_pulse;
    logic       rx_clock_from_timer;
    logic       tx_clock_from_timer;
    logic       irq;
    int         fails;
    int         cmp_count;

    timer2_capture_reload u_dut (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
        .sfr_wdata(sfr_wdata), .sfr_rd(sfr_rd), .sfr_rdata(sfr_rdata), .bit_addr(bit_addr),
        .bit_wr(bit_wr), .bit_wdata(bit_wdata), .count_input_pin(count_input_pin),
        .trigger_pin(trigger_pin), .rx_baud_pulse(rx_baud_pulse), .tx_baud_pulse(tx_baud_pulse),
        .rx_clock_from_timer(rx_clock_from_timer), .tx_clock_from_timer(tx_clock_from_timer), .irq(irq));

    pin_driver u_pins (.clk(clk), .count_input_pin(count_input_pin), .trigger_pin(trigger_pin));

    initial clk = 1'b0;
    always #5 clk = ~clk;

    // ----------------------------------------------------------------
    // access tasks
    // ----------------------------------------------------------------
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        sfr_addr  = a;
        sfr_wdata = d;
        sfr_wr    = 1'b1;
        @(negedge clk);
        sfr_wr = 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        sfr_addr = a;
        sfr_rd   = 1'b1;
        @(negedge clk);
        sfr_rd = 1'b0;
        @(negedge clk);
        d = sfr_rdata;
    endtask : rd

    task automatic bw(input logic [7:0] a, input logic v);
        @(negedge clk);
        bit_addr  = a;
        bit_wdata = v;
        bit_wr    = 1'b1;
        @(negedge clk);
        bit_wr = 1'b0;
    endtask : bw

    task automatic chk_rd(input string nm, input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        rd(a, d);
        `CHK(nm, exp, d)
    endtask : chk_rd

    task automatic chk16(input string nm, input logic [7:0] lo, input logic [15:0] exp);
        chk_rd(nm, lo, exp[7:0]);
        chk_rd(nm, lo + 8'h01, exp[15:8]);
    endtask : chk16

    // stop first so the count bytes are written while nothing moves
    task automatic setup(input logic [7:0] c, input logic [15:0] cnt, input logic [15:0] rl);
        wr(`T2_CTRL_ADDR, 8'h00);
        wr(`T2_COUNT_LOW_ADDR, cnt[7:0]);
        wr(`T2_COUNT_HIGH_ADDR, cnt[15:8]);
        wr(`T2_RELOAD_LOW_ADDR, rl[7:0]);
        wr(`T2_RELOAD_HIGH_ADDR, rl[15:8]);
        wr(`T2_CTRL_ADDR, c);
    endtask : setup

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : test_done

    initial
    begin
        #100000;
        fails++;
        test_done();
    end

    // ----------------------------------------------------------------
    // tests
    // ----------------------------------------------------------------
    logic [7:0]  addrs [7] = '{8'hC8, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hC9, 8'h00};
    // trigger cases: capture, reload, trigger disabled, timer stopped
    logic [7:0]  t_ctrl [4] = '{8'h0F, 8'h0E, 8'h07, 8'h0B};
    logic [7:0]  t_exp [4] = '{8'h4F, 8'h4E, 8'h07, 8'h0B};
    logic [15:0] t_cnt [4] = '{16'h1234, 16'h0010, 16'h1111, 16'h2222};
    logic [15:0] t_rl [4] = '{16'h0000, 16'h5678, 16'h0000, 16'h0000};
    logic [15:0] t_ecnt [4] = '{16'h1234, 16'h5678, 16'h1111, 16'h2222};
    logic [15:0] t_erl [4] = '{16'h1234, 16'h5678, 16'h0000, 16'h0000};
    logic [7:0]  b_mode [4] = '{8'h34, 8'h24, 8'h14, 8'h3D};
    logic [7:0]  d0;
    logic [7:0]  d1;
    int          rx_n;
    int          tx_n;

    initial
    begin
        {sfr_addr, sfr_wr, sfr_wdata, sfr_rd, bit_addr, bit_wr, bit_wdata} = '0;
        fails     = 0;
        cmp_count = 0;
        rst_n     = 1'b0;
        repeat (3) @(posedge clk);
        @(negedge clk);
        rst_n = 1'b1;

        foreach (addrs[i]) chk_rd("reset value", addrs[i], 8'h00);
        `CHK("irq after reset", 1'b0, irq)
        $display("test reset done");

        bw(8'hCB, 1'b1);
        bw(8'hC8, 1'b1);
        bw(8'hD3, 1'b1);
        chk_rd("bit set", `T2_CTRL_ADDR, 8'h09);
        bw(8'hCB, 1'b0);
        chk_rd("bit clear", `T2_CTRL_ADDR, 8'h01);
        $display("test bit access done");

        setup(8'h04, 16'hFFF8, 16'hFF00);
        repeat (20) @(negedge clk);
        bw(8'hCA, 1'b0);
        chk_rd("overflow flag", `T2_CTRL_ADDR, 8'h80);
        chk_rd("reload high", `T2_COUNT_HIGH_ADDR, 8'hFF);
        `CHK("irq overflow", 1'b1, irq)
        rd(`T2_COUNT_LOW_ADDR, d0);
        repeat (5) @(negedge clk);
        rd(`T2_COUNT_LOW_ADDR, d1);
        `CHK("stopped count", d0, d1)
        `CHK("stopped count known", 1'b0, $isunknown(d0))
        bw(8'hCF, 1'b0);
        chk_rd("flag cleared", `T2_CTRL_ADDR, 8'h00);
        `CHK("irq cleared", 1'b0, irq)
        $display("test autoreload overflow done");

        // capture mode without trigger: plain timer that wraps and flags
        setup(8'h05, 16'hFFF0, 16'h1234);
        repeat (20) @(negedge clk);
        bw(8'hCA, 1'b0);
        chk_rd("capture overflow", `T2_CTRL_ADDR, 8'h81);
        chk16("capture no reload", `T2_RELOAD_LOW_ADDR, 16'h1234);
        chk_rd("capture wrap", `T2_COUNT_HIGH_ADDR, 8'h00);
        $display("test capture timer done");

        foreach (t_ctrl[i])
        begin
            setup(t_ctrl[i], t_cnt[i], t_rl[i]);
            u_pins.pulse_pin(1'b1);
            chk_rd("trigger ctrl", `T2_CTRL_ADDR, t_exp[i]);
            chk16("trigger reload", `T2_RELOAD_LOW_ADDR, t_erl[i]);
            chk16("trigger count", `T2_COUNT_LOW_ADDR, t_ecnt[i]);
            `CHK("trigger irq", t_exp[i][6], irq)
        end
        $display("test trigger done");

        for (int i = 0; i < 2; i++)
        begin
            setup((i == 1) ? 8'h06 : 8'h02, 16'h00FE, 16'h0000);
            repeat (3) u_pins.pulse_pin(1'b0);
            chk16("pin count", `T2_COUNT_LOW_ADDR, (i == 1) ? 16'h0101 : 16'h00FE);
        end
        $display("test count pin done");

        foreach (b_mode[i])
        begin
            setup(b_mode[i], 16'hFFFC, 16'hFFFC);
            if (b_mode[i][3])
                u_pins.pulse_pin(1'b1);
            repeat (8) @(negedge clk);
            rx_n = 0;
            tx_n = 0;
            repeat (40)
            begin
                @(negedge clk);
                rx_n += (rx_baud_pulse === 1'b1);
                tx_n += (tx_baud_pulse === 1'b1);
            end
            // reload FFFC gives one overflow every four cycles
            `CHK("rx pulses", b_mode[i][5] ? 10 : 0, rx_n)
            `CHK("tx pulses", b_mode[i][4] ? 10 : 0, tx_n)
            `CHK("rx select", b_mode[i][5], rx_clock_from_timer)
            `CHK("tx select", b_mode[i][4], tx_clock_from_timer)
            chk_rd("baud ctrl", `T2_CTRL_ADDR, b_mode[i] | {1'b0, b_mode[i][3], 6'h00});
            chk16("baud reload", `T2_RELOAD_LOW_ADDR, 16'hFFFC);
            `CHK("baud irq", b_mode[i][3], irq)
        end
        $display("test baud done");

        test_done();
    end
endmodule : tb_top
